// ===== rtl/srt16_pkg.sv
// package for the split reload timer: register map, field positions, dividers
// assumes a 32-bit AHB-Lite register bus with word-aligned registers
`default_nettype none

package srt16_pkg;

  // -----------------------------------------------------------------
  // bus geometry
  // -----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int DEC_W = 8;

  // -----------------------------------------------------------------
  // register offsets (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [DEC_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [DEC_W-1:0] OFF_CKCFG = 8'h04;
  localparam logic [DEC_W-1:0] OFF_CNT_L = 8'h08;
  localparam logic [DEC_W-1:0] OFF_CNT_H = 8'h0C;
  localparam logic [DEC_W-1:0] OFF_RLD_L = 8'h10;
  localparam logic [DEC_W-1:0] OFF_RLD_H = 8'h14;
  localparam logic [DEC_W-1:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [DEC_W-1:0] OFF_IRQ_STAT = 8'h1C;

  // -----------------------------------------------------------------
  // timer_control_reg fields
  // -----------------------------------------------------------------
  localparam int CTRL_HOVF = 7;
  localparam int CTRL_LOVF = 6;
  localparam int CTRL_LIEN = 5;
  localparam int CTRL_SPLIT = 3;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_XCLK = 0;

  // -----------------------------------------------------------------
  // clock_config_reg fields
  // -----------------------------------------------------------------
  localparam int CK_HSEL = 5;
  localparam int CK_LSEL = 4;

  // -----------------------------------------------------------------
  // interrupt status and mask layout
  // -----------------------------------------------------------------
  localparam int IRQ_HI = 0;
  localparam int IRQ_LO = 1;
  localparam int IRQ_W = 2;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h2;

  // -----------------------------------------------------------------
  // counting and dividers
  // -----------------------------------------------------------------
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
  localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIV - 1);

endpackage : srt16_pkg

`default_nettype wire

// ===== rtl/srt16_tick_if.sv
// tick strobes passed from the prescaler to the timer core
// assumes both ends run on the same system clock
`default_nettype none

interface srt16_tick_if;
  logic tick_div12;
  logic tick_ext8;
  modport src (output tick_div12, output tick_ext8);
  modport snk (input tick_div12, input tick_ext8);
endinterface : srt16_tick_if

`default_nettype wire

// ===== rtl/srt16_tick_gen.sv
// prescaler: system clock / 12 strobe and external oscillator / 8 strobe
// assumes ext_osc is asynchronous and much slower than mclk
`default_nettype none

module srt16_tick_gen
  import srt16_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ext_osc,
  srt16_tick_if.src tk
);

  // -----------------------------------------------------------------
  // system clock divider
  // -----------------------------------------------------------------
  logic [3:0] div12_cnt;
  wire div12_last = (div12_cnt == SYS_DIV_LAST);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      div12_cnt <= '0;
      tk.tick_div12 <= 1'b0;
    end
    else
    begin
      div12_cnt <= div12_last ? 4'h0 : div12_cnt + 4'h1;
      tk.tick_div12 <= div12_last;
    end
  end

  // -----------------------------------------------------------------
  // external oscillator: synchronise, find rising edges, divide by 8
  // -----------------------------------------------------------------
  logic osc_meta;
  logic osc_sync;
  logic osc_prev;
  logic [2:0] ext_cnt;
  wire osc_rise = osc_sync & ~osc_prev;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
      ext_cnt <= '0;
      tk.tick_ext8 <= 1'b0;
    end
    else
    begin
      osc_meta <= ext_osc;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
      if (osc_rise)
      begin
        ext_cnt <= ext_cnt + 3'h1;
      end
      tk.tick_ext8 <= osc_rise & (ext_cnt == EXT_DIV_LAST);
    end
  end

endmodule : srt16_tick_gen

`default_nettype wire

// ===== rtl/srt16_timer.sv
// split reload timer: 16-bit or dual 8-bit auto-reload timer with AHB-Lite registers
// assumes a single AHB-Lite master, word transfers, hready tied to hreadyout
`default_nettype none

// Notes on behaviour
// - count is two bytes; split select picks one 16-bit or two 8-bit reload timers
// - ticks are system clock, clock/12 or synchronised external oscillator/8
// - 16-bit rollover from 0xFFFF loads both reload bytes and sets high flag
// - 16-bit mode interrupt on each overflow when timer interrupt enabled
// - 16-bit mode low-byte rollover also interrupts when low interrupt enable set
// - split mode: each byte reloads from its own reload byte
// - split mode: run control gates the high byte only
// - split mode: low byte always counts
// - split high tick: system clock if its select set, else clock/12 or ext/8
// - split low tick: system clock if its select set, else clock/12 or ext/8
// - split mode: each byte rolling over from 0xFF loads its reload byte and sets its own flag
// - split mode interrupts on high overflow, and low too if low enable set
// - flags stay set until software clears them
// - low flag set on every low-byte rollover in either mode
// - 16-bit mode uses low clock select; high clock select ignored
module srt16_timer
  import srt16_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ext_osc,
  input wire logic hsel,
  input wire logic [srt16_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [srt16_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic [srt16_pkg::DATA_W-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);

  import srt16_pkg::*;

  // -----------------------------------------------------------------
  // prescaler
  // -----------------------------------------------------------------
  srt16_tick_if tk ();

  srt16_tick_gen u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .ext_osc(ext_osc),
    .tk(tk)
  );

  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0] count_low_byte;
  logic [7:0] count_high_byte;
  logic [7:0] reload_low_byte;
  logic [7:0] reload_high_byte;
  logic high_overflow_flag;
  logic low_overflow_flag;
  logic low_byte_irq_enable;
  logic split_mode_sel;
  logic run_control;
  logic external_clock_select;
  logic high_byte_clock_select;
  logic low_byte_clock_select;
  logic [IRQ_W-1:0] irq_mask;

  // -----------------------------------------------------------------
  // bus slave: address phase capture
  // -----------------------------------------------------------------
  logic wr_act;
  logic [DEC_W-1:0] wr_addr;
  logic rd_wait;
  logic [DEC_W-1:0] rd_addr;

  wire addr_ok = hsel & htrans[1] & hready;
  wire rd_req = addr_ok & ~hwrite;
  // a read behind a write waits one cycle so it sees the written value
  wire rd_stall = rd_req & wr_act;
  wire [DEC_W-1:0] rd_sel = rd_wait ? rd_addr : haddr[DEC_W-1:0];
  wire rd_load = rd_wait | (rd_req & ~wr_act);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      wr_act <= 1'b0;
      wr_addr <= '0;
      rd_wait <= 1'b0;
      rd_addr <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      wr_act <= addr_ok & hwrite;
      wr_addr <= haddr[DEC_W-1:0];
      rd_wait <= rd_stall;
      rd_addr <= haddr[DEC_W-1:0];
      hreadyout <= ~rd_stall;
      hresp <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // write decode
  // -----------------------------------------------------------------
  wire wr_ctrl = wr_act & (wr_addr == OFF_CTRL);
  wire wr_ckcfg = wr_act & (wr_addr == OFF_CKCFG);
  wire wr_cnt_l = wr_act & (wr_addr == OFF_CNT_L);
  wire wr_cnt_h = wr_act & (wr_addr == OFF_CNT_H);
  wire wr_rld_l = wr_act & (wr_addr == OFF_RLD_L);
  wire wr_rld_h = wr_act & (wr_addr == OFF_RLD_H);
  wire wr_mask = wr_act & (wr_addr == OFF_IRQ_MASK);
  wire wr_stat = wr_act & (wr_addr == OFF_IRQ_STAT);

  // flags clear by writing zero in the control register or one in the status register
  wire clr_high = (wr_ctrl & ~hwdata[CTRL_HOVF]) | (wr_stat & hwdata[IRQ_HI]);
  wire clr_low = (wr_ctrl & ~hwdata[CTRL_LOVF]) | (wr_stat & hwdata[IRQ_LO]);

  // -----------------------------------------------------------------
  // tick selection
  // -----------------------------------------------------------------
  wire tick_slow = external_clock_select ? tk.tick_ext8 : tk.tick_div12;
  wire tick_low_src = low_byte_clock_select ? 1'b1 : tick_slow;
  wire tick_high_src = high_byte_clock_select ? 1'b1 : tick_slow;

  wire tick_word = ~split_mode_sel & run_control & tick_low_src;
  wire tick_low8 = split_mode_sel & tick_low_src;
  wire tick_high8 = split_mode_sel & run_control & tick_high_src;

  // -----------------------------------------------------------------
  // count datapath
  // -----------------------------------------------------------------
  wire [15:0] count_word = {count_high_byte, count_low_byte};
  wire [15:0] reload_word = {reload_high_byte, reload_low_byte};
  wire word_roll = tick_word & (count_word == WORD_MAX);
  wire [15:0] word_next = word_roll ? reload_word : count_word + 16'h0001;

  wire low8_roll = tick_low8 & (count_low_byte == BYTE_MAX);
  wire high8_roll = tick_high8 & (count_high_byte == BYTE_MAX);
  wire [7:0] low8_next = low8_roll ? reload_low_byte : count_low_byte + 8'h01;
  wire [7:0] high8_next = high8_roll ? reload_high_byte : count_high_byte + 8'h01;

  // low byte passing 0xFF in 16-bit mode counts as a low rollover
  wire low_roll_any = low8_roll | (tick_word & (count_low_byte == BYTE_MAX));
  wire high_roll_any = word_roll | high8_roll;

  logic [7:0] next_count_low;
  logic [7:0] next_count_high;

  always_comb
  begin
    next_count_low = count_low_byte;
    next_count_high = count_high_byte;
    if (tick_word)
    begin
      next_count_low = word_next[7:0];
      next_count_high = word_next[15:8];
    end
    if (tick_low8)
    begin
      next_count_low = low8_next;
    end
    if (tick_high8)
    begin
      next_count_high = high8_next;
    end
    // a software write to a count byte takes precedence over counting
    if (wr_cnt_l)
    begin
      next_count_low = hwdata[7:0];
    end
    if (wr_cnt_h)
    begin
      next_count_high = hwdata[7:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      count_low_byte <= BYTE_RST;
      count_high_byte <= BYTE_RST;
    end
    else
    begin
      count_low_byte <= next_count_low;
      count_high_byte <= next_count_high;
    end
  end

  // -----------------------------------------------------------------
  // overflow flags: a rollover in the clearing cycle still sets the flag
  // -----------------------------------------------------------------
  wire next_high_flag = high_roll_any | (high_overflow_flag & ~clr_high);
  wire next_low_flag = low_roll_any | (low_overflow_flag & ~clr_low);

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
    end
    else
    begin
      high_overflow_flag <= next_high_flag;
      low_overflow_flag <= next_low_flag;
    end
  end

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      reload_low_byte <= BYTE_RST;
      reload_high_byte <= BYTE_RST;
      low_byte_irq_enable <= 1'b0;
      split_mode_sel <= 1'b0;
      run_control <= 1'b0;
      external_clock_select <= 1'b0;
      high_byte_clock_select <= 1'b0;
      low_byte_clock_select <= 1'b0;
      irq_mask <= MASK_RST;
    end
    else
    begin
      if (wr_rld_l)
      begin
        reload_low_byte <= hwdata[7:0];
      end
      if (wr_rld_h)
      begin
        reload_high_byte <= hwdata[7:0];
      end
      if (wr_ctrl)
      begin
        low_byte_irq_enable <= hwdata[CTRL_LIEN];
        split_mode_sel <= hwdata[CTRL_SPLIT];
        run_control <= hwdata[CTRL_RUN];
        external_clock_select <= hwdata[CTRL_XCLK];
      end
      if (wr_ckcfg)
      begin
        high_byte_clock_select <= hwdata[CK_HSEL];
        low_byte_clock_select <= hwdata[CK_LSEL];
      end
      if (wr_mask)
      begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // interrupt: bit IRQ_HI of the mask is the timer interrupt enable
  // -----------------------------------------------------------------
  wire timer_irq_enable = irq_mask[IRQ_HI];
  wire irq_high = timer_irq_enable & next_high_flag;
  wire irq_low = timer_irq_enable & irq_mask[IRQ_LO] & low_byte_irq_enable & next_low_flag;

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_high | irq_low;
    end
  end

  // -----------------------------------------------------------------
  // read mux, registered into hrdata
  // -----------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;

  always_comb
  begin
    rd_word = '0;
    unique case (rd_sel)
      OFF_CTRL:
      begin
        rd_word[CTRL_HOVF] = high_overflow_flag;
        rd_word[CTRL_LOVF] = low_overflow_flag;
        rd_word[CTRL_LIEN] = low_byte_irq_enable;
        rd_word[CTRL_SPLIT] = split_mode_sel;
        rd_word[CTRL_RUN] = run_control;
        rd_word[CTRL_XCLK] = external_clock_select;
      end
      OFF_CKCFG:
      begin
        rd_word[CK_HSEL] = high_byte_clock_select;
        rd_word[CK_LSEL] = low_byte_clock_select;
      end
      OFF_CNT_L: rd_word[7:0] = count_low_byte;
      OFF_CNT_H: rd_word[7:0] = count_high_byte;
      OFF_RLD_L: rd_word[7:0] = reload_low_byte;
      OFF_RLD_H: rd_word[7:0] = reload_high_byte;
      OFF_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
      OFF_IRQ_STAT:
      begin
        rd_word[IRQ_HI] = high_overflow_flag;
        rd_word[IRQ_LO] = low_overflow_flag;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      hrdata <= '0;
    end
    else if (rd_load)
    begin
      hrdata <= rd_word;
    end
  end

endmodule : srt16_timer

`default_nettype wire

// ===== verification/srt16_timer_checker.sv
// checker for the split reload timer: bus answers and interrupt gating
// assumes one AHB-Lite master with hready tied to hreadyout
`default_nettype none

module srt16_timer_checker
  import srt16_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [srt16_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [srt16_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  input wire logic [srt16_pkg::DATA_W-1:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq
);
  logic ap_wr;
  logic [7:0] ap_a;
  logic en_sh;
  wire logic wdone = ap_wr & hready;
  wire logic rdap = hsel & htrans[1] & ~hwrite;

  // -----------------------------------------------------------------
  // shadow of the bus write phase and the timer interrupt enable
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      ap_wr <= 1'b0;
      ap_a <= 8'h00;
      en_sh <= 1'b0;
    end
    else if (hready)
    begin
      ap_wr <= hsel & htrans[1] & hwrite;
      ap_a <= haddr[7:0];
      if (ap_wr && ap_a == OFF_IRQ_MASK)
        en_sh <= hwdata[0];
    end
  end

  // -----------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_RST_OUT: assert property (disable iff (1'b0) !rst_b |=> !irq && hreadyout && !hresp)
    else $error("outputs not idle after reset");
  AST_IRQ_GATE: assert property (irq |-> $past(en_sh))
    else $error("interrupt high with timer interrupt disabled");
  AST_IRQ_HOLD: assert property ($fell(irq) |-> $past(wdone) || $past(wdone, 2))
    else $error("interrupt dropped without a software write");
  AST_MASK_OFF: assert property (wdone && ap_a == OFF_IRQ_MASK && !hwdata[0] |-> ##[1:2] !irq)
    else $error("interrupt stays high after disable");
  AST_READY_ONE: assert property (!hreadyout |=> hreadyout)
    else $error("stall longer than one cycle");
  AST_STALL_WHY: assert property (!hreadyout |-> $past(rdap && ap_wr))
    else $error("stall without read behind write");
  AST_RD_HOLD: assert property ($changed(hrdata) |-> $past(rdap) || $past(rdap, 2))
    else $error("read data changed without a read");
  AST_OKAY: assert property (hreadyout |-> !hresp)
    else $error("error response seen");

endmodule : srt16_timer_checker

bind srt16_timer srt16_timer_checker chk_u (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

`default_nettype wire

// ===== verification/srt16_timer_tb.sv
// testbench for the split reload timer: registers, both modes, all tick sources
// assumes the checker is bound in its own file
`default_nettype none

module srt16_timer_tb
  import srt16_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_b, hsel, hwrite;
  logic ext_osc = 1'b0;
  logic [31:0] haddr, hwdata, q, q2;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int ec = 0;

  srt16_timer dut_u (.mclk(mclk), .rst_b(rst_b), .ext_osc(ext_osc), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

  // -----------------------------------------------------------------
  // clock, external oscillator (period 6 cycles), timeout
  // -----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    ec <= (ec == 2) ? 0 : ec + 1;
    if (ec == 2)
      ext_osc <= ~ext_osc;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  // -----------------------------------------------------------------
  // bus and checking tasks
  // -----------------------------------------------------------------
  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wait_rdy();
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask : wait_rdy

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= 1'b1;
    haddr <= {24'h000000, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    wait_rdy();
  endtask : wr

  // a read, preceded when wfirst is set by a write and addressed during its data phase
  task automatic rd(input logic [7:0] a, output logic [31:0] r, input logic wfirst = 1'b0,
    input logic [7:0] d = 8'h00);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wfirst;
    if (wfirst)
    begin
      wait_rdy();
      hwrite <= 1'b0;
      hwdata <= {24'h000000, d};
    end
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    wait_rdy();
    r = hrdata;
  endtask : rd

  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge mclk);
    chk("irq", {31'h0, irq}, {31'h0, exp});
  endtask : chk_irq

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    rd(OFF_CTRL, q);
    chk("ctrl reset", q, 32'h0);
    rd(OFF_IRQ_MASK, q);
    chk("mask reset", q, 32'h2);
    rd(8'h40, q, 1'b1, 8'hFF);
    chk("unmapped", q, 32'h0);
  endtask : t_reset

  task automatic t_wide();
    wr(OFF_IRQ_MASK, 8'h03);
    wr(OFF_CKCFG, 8'h10);
    rd(OFF_RLD_L, q, 1'b1, 8'hF0);
    chk("reload low", q, 32'hF0);
    wr(OFF_RLD_H, 8'hFF);
    wr(OFF_CNT_L, 8'hFD);
    wr(OFF_CNT_H, 8'hFF);
    wr(OFF_CTRL, 8'h04);
    repeat (10) @(posedge mclk);
    wr(OFF_CTRL, 8'hC0);
    rd(OFF_IRQ_STAT, q);
    chk("flags wide", q, 32'h3);
    rd(OFF_CNT_H, q);
    chk("high reload", q, 32'hFF);
    rd(OFF_CNT_L, q);
    rd(OFF_CNT_L, q2);
    chk("stopped", q2, q);
    chk_irq(1'b1);
  endtask : t_wide

  task automatic t_clear();
    repeat (40) @(posedge mclk);
    rd(OFF_IRQ_STAT, q);
    chk("flags kept", q, 32'h3);
    wr(OFF_IRQ_STAT, 8'h03);
    rd(OFF_CTRL, q);
    chk("flags cleared", q, 32'h0);
    chk_irq(1'b0);
  endtask : t_clear

  task automatic t_split_low();
    wr(OFF_CNT_L, 8'hFE);
    wr(OFF_CNT_H, 8'h55);
    wr(OFF_CTRL, 8'h08);
    repeat (20) @(posedge mclk);
    rd(OFF_IRQ_STAT, q);
    chk("low flag only", q, 32'h2);
    rd(OFF_CNT_H, q);
    chk("high gated", q, 32'h55);
    rd(OFF_CNT_L, q);
    chk("low reload", 32'(q >= 32'hF0 && q <= 32'hFF), 32'h1);
    chk_irq(1'b0);
    wr(OFF_CTRL, 8'h68);
    chk_irq(1'b1);
  endtask : t_split_low

  task automatic t_split_high();
    wr(OFF_CKCFG, 8'h20);
    wr(OFF_CNT_H, 8'hFE);
    wr(OFF_RLD_H, 8'h80);
    wr(OFF_CTRL, 8'h0C);
    repeat (5) @(posedge mclk);
    rd(OFF_IRQ_STAT, q);
    chk("high flag", q & 32'h1, 32'h1);
    rd(OFF_CNT_H, q);
    chk("high reload", 32'(q >= 32'h80 && q <= 32'hFF), 32'h1);
    chk_irq(1'b1);
    wr(OFF_IRQ_MASK, 8'h02);
    chk_irq(1'b0);
    wr(OFF_IRQ_MASK, 8'h03);
  endtask : t_split_high

  task automatic t_div12();
    wr(OFF_CTRL, 8'h04);
    // low byte first: a tick between the two writes cannot carry into the high byte
    wr(OFF_CNT_L, 8'h00);
    wr(OFF_CNT_H, 8'h00);
    repeat (120) @(posedge mclk);
    rd(OFF_CNT_L, q);
    chk("div12 count", 32'(q >= 9 && q <= 11), 32'h1);
    rd(OFF_CNT_H, q);
    chk("div12 high", q, 32'h0);
    // 16-bit mode low-byte rollover alone, with the low interrupt enabled
    wr(OFF_CTRL, 8'h24);
    wr(OFF_CNT_L, 8'hFE);
    repeat (30) @(posedge mclk);
    rd(OFF_IRQ_STAT, q);
    chk("low flag wide", q, 32'h2);
    chk_irq(1'b1);
  endtask : t_div12

  task automatic t_ext8();
    wr(OFF_CKCFG, 8'h00);
    wr(OFF_CTRL, 8'h09);
    wr(OFF_CNT_H, 8'h33);
    wr(OFF_CNT_L, 8'h00);
    repeat (480) @(posedge mclk);
    rd(OFF_CNT_L, q);
    chk("ext8 count", 32'(q >= 9 && q <= 11), 32'h1);
    rd(OFF_CNT_H, q);
    chk("ext8 high", q, 32'h33);
  endtask : t_ext8

  initial
  begin
    rst_b = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    t_reset();
    t_wide();
    t_clear();
    t_split_low();
    t_split_high();
    t_div12();
    t_ext8();
    give_verdict();
  end

endmodule : srt16_timer_tb

`default_nettype wire
